/* File: hdl/hpsc_ctrl.v */
// hpsc_ctrl.v: digital control of a board power switch with fault logging
// assumes comparator outputs and pins are asynchronous and synchronised here
`include "hpsc_regs.vh"
`default_nettype none

// Behaviour
// - gate may turn on only while board-present input is low
// - every change of board-present level is logged as a fault entry
// - board-present falling edge samples turn-on input and clears faults
// - turn-on rising edge switches on, falling edge switches off
// - turn-on high at power-up sets switch-on bit 100 ms later
// - turn-on low at power-up stays off until host sets switch-on bit or turn-on rises
// - turn-on falling edge clears the fault register
// - power bad when feedback low; two bits set power-good io behaviour
// - power-bad fault logged only after start-up with gate on
// - io1 pulls low when its drive bit clear; level bit mirrors pin
// - io1 may output power-good or power-bad state, also a status bit
// - io2 pulls low when its drive bit set; level bit mirrors pin
// - io2 pulls low as alert for enabled faults; default released
// - io3 pulls low when drive bit set, low by default; level mirrored
// - overvoltage logs a fault and turns gate off
// - undervoltage logs a fault and turns gate off
// - undervoltage input below reset level clears faults, allows turn-on
// - overcurrent fault logged if current limited at start-up end
// - auto-retry holds switch off for cool-down, one-to-fifty duty
// - internal timers: 100 ms start-up, 5 s cool-down
// - serial data shifted on rising edges of serial clock
// - slave address from two three-state inputs, nine addresses
// - input range and board present must hold 100 ms before turn-on
// - power-on reset clears faults and sets control defaults
module hpsc_ctrl #(
    parameter DEBOUNCE_CYC = (`HPSC_CLK_HZ / 1000) * `HPSC_DEBOUNCE_MS,
    parameter STARTUP_CYC  = (`HPSC_CLK_HZ / 1000) * `HPSC_STARTUP_MS,
    parameter COOLDOWN_CYC = `HPSC_CLK_HZ * `HPSC_COOLDOWN_S,
    parameter CNT_W        = 28
) (
    // clock, reset, enable
    input  wire                      clk,
    input  wire                      sys_rst,
    input  wire                      clk_en,
    // comparator and pin inputs (asynchronous)
    input  wire                      board_present_n,
    input  wire                      turn_on_in,
    input  wire                      overvoltage_input,
    input  wire                      undervoltage_input,
    input  wire                      uv_reset_low,
    input  wire                      output_feedback_input,
    input  wire                      current_limit_in,
    input  wire                      timer_internal,
    input  wire                      startup_timer_done,
    input  wire                      cooldown_timer_done,
    // host control bits
    input  wire                      host_switch_on_set,
    input  wire                      host_switch_on_clr,
    input  wire                      host_fault_clr,
    input  wire                      autoretry_oc_en,
    input  wire                      pgood_cfg_bit_lo,
    input  wire                      pgood_cfg_bit_hi,
    input  wire                      io1_drive_bit,
    input  wire                      io2_drive_bit,
    input  wire                      io3_drive_bit,
    input  wire [`HPSC_FAULT_W-1:0]  alert_enable,
    // serial pins
    input  wire                      serial_clk,
    input  wire                      serial_data_in,
    input  wire [1:0]                slave_addr_sel0,
    input  wire [1:0]                slave_addr_sel1,
    output wire                      serial_rise,
    output reg                       serial_bit_r,
    output reg  [3:0]                slave_addr_r,
    // open-drain io pins
    input  wire                      power_good_io_in,
    output wire                      power_good_io_out,
    output wire                      power_good_io_oe,
    input  wire                      alert_io_in,
    output wire                      alert_io_out,
    output wire                      alert_io_oe,
    input  wire                      aux_io_in,
    output wire                      aux_io_out,
    output wire                      aux_io_oe,
    // status
    output reg                       gate_on_r,
    output reg                       switch_on_bit_r,
    output reg  [`HPSC_FAULT_W-1:0]  fault_r,
    output reg                       power_bad_status_bit_r,
    output reg                       io1_level_bit_r,
    output reg                       io2_level_bit_r,
    output reg                       io3_level_bit_r,
    output reg                       startup_done_r
);

// ----------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------
localparam NS = 15;
wire [NS-1:0] raw = {serial_data_in, serial_clk, aux_io_in, alert_io_in,
                     power_good_io_in, cooldown_timer_done, startup_timer_done,
                     timer_internal, current_limit_in, output_feedback_input,
                     uv_reset_low, undervoltage_input, overvoltage_input,
                     turn_on_in, board_present_n};
reg  [NS-1:0] s1_r;
reg  [NS-1:0] s2_r;
reg  [NS-1:0] s3_r;
genvar gi;
generate
    for (gi = 0; gi < NS; gi = gi + 1)
    begin : g_sync
        always @(posedge clk)
        begin
            if (sys_rst)
            begin
                s1_r[gi] <= 1'h0;
                s2_r[gi] <= 1'h0;
                s3_r[gi] <= 1'h0;
            end
            else if (clk_en)
            begin
                s1_r[gi] <= raw[gi];
                s2_r[gi] <= s1_r[gi];
                s3_r[gi] <= s2_r[gi];
            end
        end
    end
endgenerate

// edges and fault sets wait until the third stage holds real pin samples;
// otherwise the reset zeros look like a level change on every idle-high pin
reg  [1:0] settle_r;
always @(posedge clk)
begin
    if (sys_rst)
        settle_r <= 2'h0;
    else if (clk_en && (settle_r != `HPSC_SYNC_SETTLE))
        settle_r <= settle_r + 2'h1;
end
wire settled    = (settle_r == `HPSC_SYNC_SETTLE);

wire present_n  = s2_r[0];
wire on_lvl     = s2_r[1];
wire ov         = s2_r[2];
wire uv         = s2_r[3];
wire uv_rst     = s2_r[4];
wire fb_ok      = s2_r[5];
wire ilim       = s2_r[6];
wire tmr_int    = s2_r[7];
wire ext_su     = s2_r[8];
wire ext_cd     = s2_r[9];
wire present_fe = settled & s3_r[0] & ~s2_r[0];
wire present_ch = settled & (s3_r[0] ^ s2_r[0]);
wire on_re      = settled & ~s3_r[1] & s2_r[1];
wire on_fe      = settled & s3_r[1] & ~s2_r[1];

// ----------------------------------------------------------------
// serial pins: sampling only, protocol lives elsewhere
// ----------------------------------------------------------------
assign serial_rise = settled & ~s3_r[13] & s2_r[13] & clk_en;

// strap capture after reset release, not under reset
reg addr_taken_r;
always @(posedge clk)
begin
    if (sys_rst)
    begin
        serial_bit_r <= 1'h0;
        slave_addr_r <= 4'h0;
        addr_taken_r <= 1'h0;
    end
    else if (clk_en)
    begin
        if (serial_rise)
            serial_bit_r <= s2_r[14];
        if (!addr_taken_r)
        begin
            slave_addr_r <= ((slave_addr_sel1 > 2'h2) ? 4'h2 : {2'h0, slave_addr_sel1}) * 4'h3
                          + ((slave_addr_sel0 > 2'h2) ? 4'h2 : {2'h0, slave_addr_sel0});
            addr_taken_r <= 1'h1;
        end
    end
end

// ----------------------------------------------------------------
// power-up hold-off and input qualification
// ----------------------------------------------------------------
wire inputs_ok = ~ov & uv & ~present_n;
reg  [CNT_W-1:0] qual_cnt_r;
reg              qualified_r;
reg              first_qual_r;
always @(posedge clk)
begin
    if (sys_rst)
    begin
        qual_cnt_r   <= {CNT_W{1'b0}};
        qualified_r  <= 1'h0;
        first_qual_r <= 1'h1;
    end
    else if (clk_en)
    begin
        if (!inputs_ok)
        begin
            qual_cnt_r  <= {CNT_W{1'b0}};
            qualified_r <= 1'h0;
        end
        else if (qual_cnt_r < DEBOUNCE_CYC[CNT_W-1:0] - 1'b1)
            qual_cnt_r <= qual_cnt_r + 1'b1;
        else
        begin
            qualified_r <= 1'h1;
            if (!qualified_r)
                first_qual_r <= 1'h0;
        end
    end
end
wire qual_rise = inputs_ok && !qualified_r && (qual_cnt_r == DEBOUNCE_CYC[CNT_W-1:0] - 1'b1);

// ----------------------------------------------------------------
// start-up timer and auto-retry cool-down
// ----------------------------------------------------------------
reg  [CNT_W-1:0] su_cnt_r;
reg  [CNT_W-1:0] cd_cnt_r;
reg              cooling_r;
wire su_end  = tmr_int ? (su_cnt_r == STARTUP_CYC[CNT_W-1:0] - 1'b1) : ext_su;
wire cd_end  = tmr_int ? (cd_cnt_r == COOLDOWN_CYC[CNT_W-1:0] - 1'b1) : ext_cd;
wire oc_trip = gate_on_r & ~startup_done_r & su_end & ilim;

// ----------------------------------------------------------------
// switch control and fault logging
// ----------------------------------------------------------------
wire pbad = ~fb_ok;
reg  [`HPSC_FAULT_W-1:0] fault_set;
reg                      fault_clear;
always @*
begin
    fault_set = {`HPSC_FAULT_W{1'b0}};
    fault_set[`HPSC_F_OV]      = ov;
    fault_set[`HPSC_F_UV]      = ~uv & ~uv_rst;
    fault_set[`HPSC_F_OC]      = oc_trip;
    fault_set[`HPSC_F_PBAD]    = pbad & startup_done_r & gate_on_r;
    fault_set[`HPSC_F_PRESENT] = present_ch;
    if (!settled)
        fault_set = {`HPSC_FAULT_W{1'b0}};
    fault_clear = present_fe | on_fe | uv_rst | host_fault_clr;
end

always @(posedge clk)
begin
    if (sys_rst)
    begin
        fault_r         <= {`HPSC_FAULT_W{1'b0}};
        switch_on_bit_r <= 1'h0;
        gate_on_r       <= 1'h0;
        startup_done_r  <= 1'h0;
        su_cnt_r        <= {CNT_W{1'b0}};
        cd_cnt_r        <= {CNT_W{1'b0}};
        cooling_r       <= 1'h0;
    end
    else if (clk_en)
    begin
        // set wins over clear so no event is lost
        fault_r <= (fault_clear ? {`HPSC_FAULT_W{1'b0}} : fault_r) | fault_set;

        // switch-on bit
        if (first_qual_r && qual_rise)
            switch_on_bit_r <= on_lvl;
        else if (present_fe)
            switch_on_bit_r <= on_lvl;
        else if (on_re || host_switch_on_set)
            switch_on_bit_r <= 1'h1;
        else if (on_fe || host_switch_on_clr || oc_trip)
            switch_on_bit_r <= 1'h0;

        // gate: off on any hard fault; latched overvoltage and undervoltage faults hold it off until cleared
        if (!qualified_r || ov || !uv || !switch_on_bit_r || cooling_r
            || fault_r[`HPSC_F_OV] || fault_r[`HPSC_F_UV] || oc_trip)
            gate_on_r <= 1'h0;
        else
            gate_on_r <= 1'h1;

        // start-up interval restarts whenever gate drops
        if (!gate_on_r)
        begin
            su_cnt_r       <= {CNT_W{1'b0}};
            startup_done_r <= 1'h0;
        end
        else if (!startup_done_r)
        begin
            su_cnt_r <= su_cnt_r + 1'b1;
            if (su_end && !ilim)
                startup_done_r <= 1'h1;
        end

        // cool-down then retry; internal timer counts give the 1:50 ratio
        if (oc_trip && autoretry_oc_en)
        begin
            cooling_r <= 1'h1;
            cd_cnt_r  <= {CNT_W{1'b0}};
        end
        else if (cooling_r)
        begin
            cd_cnt_r <= cd_cnt_r + 1'b1;
            if (cd_end)
            begin
                cooling_r       <= 1'h0;
                switch_on_bit_r <= 1'h1;
            end
        end
    end
end

// ----------------------------------------------------------------
// open-drain io and status mirrors
// ----------------------------------------------------------------
wire [1:0] pg_cfg   = {pgood_cfg_bit_hi, pgood_cfg_bit_lo};
wire       pg_view  = ~startup_done_r | pbad;
reg        io1_low;
always @*
begin
    if (pg_cfg == `HPSC_PG_GOOD)
        io1_low = pg_view;
    else if (pg_cfg == `HPSC_PG_BAD)
        io1_low = ~pg_view;
    else
        io1_low = ~io1_drive_bit;
end
wire alert = |(fault_r & alert_enable);

assign power_good_io_out = 1'h0;
assign power_good_io_oe  = io1_low;
assign alert_io_out      = 1'h0;
assign alert_io_oe       = io2_drive_bit | alert;
assign aux_io_out        = 1'h0;
assign aux_io_oe         = io3_drive_bit;

always @(posedge clk)
begin
    if (sys_rst)
    begin
        power_bad_status_bit_r <= `HPSC_PBAD_RST;
        io1_level_bit_r        <= 1'h0;
        io2_level_bit_r        <= 1'h0;
        io3_level_bit_r        <= 1'h0;
    end
    else if (clk_en)
    begin
        power_bad_status_bit_r <= pg_view;
        io1_level_bit_r        <= s2_r[10];
        io2_level_bit_r        <= s2_r[11];
        io3_level_bit_r        <= s2_r[12];
    end
end

endmodule // hpsc_ctrl
`default_nettype wire

/* File: hdl/hpsc_regs.vh */
// hpsc_regs.vh: constants of the power switch control block
// assumes a 25 MHz system clock; included by the design file, the monitor and the bench
`ifndef HPSC_REGS_VH
`define HPSC_REGS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HPSC_CLK_HZ        25000000
`define HPSC_DEBOUNCE_MS   100
`define HPSC_STARTUP_MS    100
`define HPSC_COOLDOWN_S    5
`define HPSC_RETRY_RATIO   50
`define HPSC_SYNC_SETTLE   2'h3

// ----------------------------------------------------------------
// fault bit positions
// ----------------------------------------------------------------
`define HPSC_F_OV          0
`define HPSC_F_UV          1
`define HPSC_F_OC          2
`define HPSC_F_PBAD        3
`define HPSC_F_PRESENT     4
`define HPSC_FAULT_W       5

// ----------------------------------------------------------------
// power-good io configuration codes {hi, lo}
// ----------------------------------------------------------------
`define HPSC_PG_GPIO       2'h0
`define HPSC_PG_GOOD       2'h1
`define HPSC_PG_BAD        2'h2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define HPSC_IO1_DRV_RST   1'h1
`define HPSC_IO2_DRV_RST   1'h0
`define HPSC_IO3_DRV_RST   1'h1
`define HPSC_ALERT_EN_RST  5'h00
`define HPSC_PBAD_RST      1'h1

`endif

/* File: tb/hpsc_ctrl_monitor.sv */
// hpsc_ctrl_monitor.sv: port assertions for the power switch control block
// assumes the block header is on the include path; attached by the bind below
`include "hpsc_regs.vh"
`default_nettype none
module hpsc_ctrl_monitor (
    // clock and reset
    input wire logic                     clk,
    input wire logic                     sys_rst,
    // pins and control bits
    input wire logic                     board_present_n,
    input wire logic                     turn_on_in,
    input wire logic                     overvoltage_input,
    input wire logic                     undervoltage_input,
    input wire logic                     uv_reset_low,
    input wire logic                     pgood_cfg_bit_lo,
    input wire logic                     pgood_cfg_bit_hi,
    input wire logic                     io1_drive_bit,
    input wire logic                     io2_drive_bit,
    input wire logic                     io3_drive_bit,
    input wire logic [`HPSC_FAULT_W-1:0] alert_enable,
    input wire logic                     serial_clk,
    // block outputs
    input wire logic                     serial_rise,
    input wire logic                     power_good_io_oe,
    input wire logic                     alert_io_oe,
    input wire logic                     aux_io_oe,
    input wire logic                     gate_on_r,
    input wire logic [`HPSC_FAULT_W-1:0] fault_r,
    input wire logic                     power_bad_status_bit_r
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic [1:0] cfg = {pgood_cfg_bit_hi, pgood_cfg_bit_lo};
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // latencies allow for the two-flop synchronisers on every pin
    property p_off_absent; board_present_n [*6] |-> !gate_on_r; endproperty
    a_off_absent: assert property (p_off_absent) else $error("gate on, no board");
    property p_present_log; $changed(board_present_n) |-> ##[1:5] fault_r[4]; endproperty
    a_present_log: assert property (p_present_log) else $error("board change unlogged");
    property p_ov; overvoltage_input [*6] |-> fault_r[0] && !gate_on_r; endproperty
    a_ov: assert property (p_ov) else $error("overvoltage missed");
    property p_uv; (!undervoltage_input && !uv_reset_low) [*6] |-> fault_r[1] && !gate_on_r; endproperty
    a_uv: assert property (p_uv) else $error("undervoltage missed");
    property p_uv_rst; uv_reset_low [*5] |-> fault_r[3:0] == 4'h0; endproperty
    a_uv_rst: assert property (p_uv_rst) else $error("faults kept in reset");
    property p_on_fall; $fell(turn_on_in) |-> ##[4:6] (!gate_on_r && fault_r == 5'h00); endproperty
    a_on_fall: assert property (p_on_fall) else $error("turn-on fall ignored");
    property p_io1; cfg == 2'h0 |-> power_good_io_oe == !io1_drive_bit; endproperty
    a_io1: assert property (p_io1) else $error("io1 drive wrong");
    // the status bit is registered, so it is held against the pin one cycle back
    property p_pg; (cfg == 2'h1 || cfg == 2'h2)
        |=> $past(power_good_io_oe) == (power_bad_status_bit_r ^ $past(cfg[1])); endproperty
    a_pg: assert property (p_pg) else $error("power good io wrong");
    property p_io2; alert_enable == 5'h00 |-> alert_io_oe == io2_drive_bit; endproperty
    a_io2: assert property (p_io2) else $error("io2 drive wrong");
    property p_alert; |(alert_enable & fault_r) |-> ##[0:1] alert_io_oe; endproperty
    a_alert: assert property (p_alert) else $error("alert not raised");
    property p_io3; aux_io_oe == io3_drive_bit; endproperty
    a_io3: assert property (p_io3) else $error("io3 drive wrong");
    property p_serial; $rose(serial_clk) |-> ##[1:4] serial_rise; endproperty
    a_serial: assert property (p_serial) else $error("serial edge missed");
endmodule // hpsc_ctrl_monitor
bind hpsc_ctrl hpsc_ctrl_monitor hpsc_ctrl_monitor_i (.clk, .sys_rst, .board_present_n,
    .turn_on_in, .overvoltage_input, .undervoltage_input, .uv_reset_low, .pgood_cfg_bit_lo,
    .pgood_cfg_bit_hi, .io1_drive_bit, .io2_drive_bit, .io3_drive_bit, .alert_enable,
    .serial_clk, .serial_rise, .power_good_io_oe, .alert_io_oe, .aux_io_oe, .gate_on_r,
    .fault_r, .power_bad_status_bit_r);
`default_nettype wire

/* File: tb/hpsc_host_model.sv */
// hpsc_host_model.sv: serial host sending one byte per request
// assumes pulled-up lines: clock idles high, released data reads high
`default_nettype none
module hpsc_host_model (
    // request
    input  wire logic       go,
    input  wire logic [7:0] data,
    // serial pins
    output var logic        scl,
    output var logic        sda,
    output var logic        busy
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
        busy = 1'b0;
    end
    // clock stands still between frames, 320 ns period within
    always @(posedge go)
    begin
        busy = 1'b1;
        for (int i = 7; i >= 0; i--)
        begin
            #80 scl = 1'b0;
            #80 sda = data[i];
            #160 scl = 1'b1;
        end
        #80 sda = 1'b1;
        busy = 1'b0;
    end
endmodule // hpsc_host_model
`default_nettype wire

/* File: tb/tb_top.sv */
// tb_top.sv: self-checking bench for the power switch control block
// assumes the block, its header and the host model are compiled alongside
`include "hpsc_regs.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int COOL = 50;
    logic clk = 1'b0, sys_rst = 1'b1, bp_n = 1'b1, ton = 1'b1, ov = 1'b0, uv = 1'b1;
    logic uvr = 1'b0, fb = 1'b0, cl = 1'b0, hs = 1'b0, hc = 1'b0, hf = 1'b0, ar = 1'b0;
    logic c_lo = 1'b0, c_hi = 1'b0, go = 1'b0, rise_d = 1'b0, en = 1'b1;
    logic [2:0] drv = {`HPSC_IO3_DRV_RST, `HPSC_IO2_DRV_RST, `HPSC_IO1_DRV_RST};
    logic [2:0] ext = 3'h7;
    logic [4:0] aen = `HPSC_ALERT_EN_RST;
    logic [1:0] s0 = 2'h0, s1 = 2'h0;
    logic [7:0] byte_v = 8'h00, got = 8'h00;
    wire scl, sda, busy, srise, sbit, gate, swb, pbad, sdone, o1, o2, o3;
    wire [2:0] lv, od;
    wire [3:0] addr;
    wire [4:0] flt;
    int miscompares = 0, comparisons = 0, k = 0;
    hpsc_ctrl #(.DEBOUNCE_CYC(20), .STARTUP_CYC(20), .COOLDOWN_CYC(COOL)) hpsc_ctrl_i (
        .clk(clk), .sys_rst(sys_rst), .clk_en(en), .board_present_n(bp_n),
        .turn_on_in(ton), .overvoltage_input(ov), .undervoltage_input(uv), .uv_reset_low(uvr),
        .output_feedback_input(fb), .current_limit_in(cl), .timer_internal(1'b1),
        .startup_timer_done(1'b0), .cooldown_timer_done(1'b0), .host_switch_on_set(hs),
        .host_switch_on_clr(hc), .host_fault_clr(hf), .autoretry_oc_en(ar),
        .pgood_cfg_bit_lo(c_lo), .pgood_cfg_bit_hi(c_hi), .io1_drive_bit(drv[0]),
        .io2_drive_bit(drv[1]), .io3_drive_bit(drv[2]), .alert_enable(aen),
        .serial_clk(scl), .serial_data_in(sda), .slave_addr_sel0(s0), .slave_addr_sel1(s1),
        .serial_rise(srise), .serial_bit_r(sbit), .slave_addr_r(addr),
        .power_good_io_in(ext[0] & ~o1), .power_good_io_out(od[0]), .power_good_io_oe(o1),
        .alert_io_in(ext[1] & ~o2), .alert_io_out(od[1]), .alert_io_oe(o2),
        .aux_io_in(ext[2] & ~o3), .aux_io_out(od[2]), .aux_io_oe(o3), .gate_on_r(gate),
        .switch_on_bit_r(swb), .fault_r(flt), .power_bad_status_bit_r(pbad),
        .io1_level_bit_r(lv[0]), .io2_level_bit_r(lv[1]), .io3_level_bit_r(lv[2]),
        .startup_done_r(sdone));
    hpsc_host_model hpsc_host_model_i (.go(go), .data(byte_v), .scl(scl), .sda(sda), .busy(busy));
    always #20 clk = ~clk;
    // bit taken the cycle after the detected rise, once the register has loaded
    always @(posedge clk)
    begin
        rise_d <= srise;
        if (rise_d)
            got <= {got[6:0], sbit};
    end
    function automatic logic [7:0] exp_addr(input logic [1:0] a1, input logic [1:0] a0);
        return {6'h0, a1} * 8'h03 + {6'h0, a0};
    endfunction
    function automatic logic [2:0] exp_oe(input logic [2:0] d);
        return {d[2], d[1], ~d[0]};
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // bounded wait for the gate; k returns the cycles spent
    task automatic wgate(input logic e, input int n);
        k = 0;
        while (gate !== e && k < n)
        begin
            cyc(1);
            k++;
        end
        chk("gate", {7'h0, e}, {7'h0, gate});
        if (gate !== e)
            results();
    endtask
    initial
    begin
        void'($urandom(90980));
        s0 = 2'($urandom_range(2));
        s1 = 2'($urandom_range(2));
        cyc(6);
        sys_rst = 1'b0;
        cyc(2);
        chk("addr", exp_addr(s1, s0), {4'h0, addr});
        chk("fault", 8'h00, {3'h0, flt});
        $display("test reset done");
        bp_n = 1'b0;
        cyc(6);
        chk("fault", 8'h10, {3'h0, flt});
        cyc(10);
        chk("gate", 8'h00, {7'h0, gate});
        wgate(1'b1, 40);
        chk("swon", 8'h01, {7'h0, swb});
        fb = 1'b1;
        cyc(30);
        chk("pbad", 8'h00, {6'h0, pbad, ~sdone});
        c_lo = 1'b1;
        fb = 1'b0;
        cyc(6);
        chk("pbfault", 8'h01, {7'h0, flt[`HPSC_F_PBAD]});
        chk("pgio", 8'h01, {7'h0, o1});
        c_lo = 1'b0;
        c_hi = 1'b1;
        cyc(1);
        chk("pgio", 8'h00, {7'h0, o1});
        c_hi = 1'b0;
        fb = 1'b1;
        ton = 1'b0;
        cyc(6);
        chk("fault", 8'h00, {6'h0, gate, |flt});
        ton = 1'b1;
        wgate(1'b1, 10);
        $display("test turn-on done");
        ov = 1'b1;
        cyc(6);
        chk("ov", 8'h01, {6'h0, gate, flt[`HPSC_F_OV]});
        ov = 1'b0;
        uv = 1'b0;
        uvr = 1'b1;
        cyc(6);
        uvr = 1'b0;
        uv = 1'b1;
        cyc(1);
        chk("fault", 8'h00, {3'h0, flt});
        wgate(1'b1, 40);
        uv = 1'b0;
        cyc(6);
        chk("uv", 8'h01, {6'h0, gate, flt[`HPSC_F_UV]});
        ton = 1'b0;
        uv = 1'b1;
        cyc(6);
        ton = 1'b1;
        wgate(1'b1, 40);
        $display("test ov uv done");
        ton = 1'b0;
        cyc(6);
        bp_n = 1'b1;
        cyc(6);
        chk("fault", 8'h10, {2'h0, gate, flt});
        bp_n = 1'b0;
        cyc(6);
        chk("swon", 8'h10, {2'h0, swb, flt});
        cyc(40);
        chk("gate", 8'h00, {7'h0, gate});
        hs = 1'b1;
        cyc(1);
        hs = 1'b0;
        wgate(1'b1, 10);
        hf = 1'b1;
        cyc(1);
        hf = 1'b0;
        cyc(1);
        chk("fault", 8'h00, {3'h0, flt});
        $display("test board present done");
        hc = 1'b1;
        cyc(1);
        hc = 1'b0;
        ar = 1'b1;
        cl = 1'b1;
        cyc(4);
        hs = 1'b1;
        cyc(1);
        hs = 1'b0;
        wgate(1'b1, 10);
        wgate(1'b0, 40);
        chk("oc", 8'h01, {7'h0, flt[`HPSC_F_OC]});
        cl = 1'b0;
        wgate(1'b1, 150);
        chk("cool", 8'h01, {7'h0, k >= COOL - 1});
        aen = 5'h01 << `HPSC_F_OC;
        cyc(2);
        chk("alert", 8'h01, {7'h0, o2});
        aen = 5'h00;
        $display("test overcurrent done");
        for (int i = 0; i < 8; i++)
        begin
            {drv, ext} = 6'($urandom());
            cyc(5);
            chk("oe", {5'h0, exp_oe(drv)}, {5'h0, o3, o2, o1});
            chk("level", {5'h0, ext & ~exp_oe(drv)}, {5'h0, lv});
            chk("odata", 8'h00, {5'h0, od});
        end
        $display("test io done");
        byte_v = 8'($urandom());
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        k = 0;
        while (busy !== 1'b0 && k < 200)
        begin
            cyc(1);
            k++;
        end
        cyc(6);
        chk("serial", byte_v, got);
        if (k == 200)
            miscompares++;
        $display("test serial done");
        // a host clear while the enable is low must change nothing
        en = 1'b0;
        hc = 1'b1;
        cyc(2);
        hc = 1'b0;
        chk("frozen", 8'h03, {6'h0, gate, swb});
        en = 1'b1;
        hc = 1'b1;
        cyc(1);
        hc = 1'b0;
        cyc(2);
        chk("thawed", 8'h00, {6'h0, gate, swb});
        $display("test clock enable done");
        results();
    end
endmodule // tb_top
`default_nettype wire
